// ---- ccpmc_pkg.sv ----
// Package of constants and types for the capture/compare/PWM mode control block.
package ccpmc_pkg;

    // ************************************************************
    // Register map, word offsets in bytes.
    // ************************************************************
    localparam logic [3:0] CCPMC_OFF_CONTROL = 4'h0;
    localparam logic [3:0] CCPMC_OFF_DATA = 4'h4;
    localparam logic [3:0] CCPMC_OFF_STATUS = 4'h8;
    localparam logic [3:0] CCPMC_OFF_IRQ_CLEAR = 4'hC;
    localparam logic [3:0] CCPMC_OFF_IRQ_ENABLE = 4'h0;

    // ************************************************************
    // Field layout and reset values.
    // ************************************************************
    localparam int CCPMC_MODE_LSB = 0;
    localparam int CCPMC_DUTY_LSB = 4;
    localparam logic [15:0] CCPMC_CONTROL_RESET = 16'h0000;
    localparam logic [15:0] CCPMC_DATA_RESET = 16'h0000;
    localparam logic [4:0] CCPMC_PRESCALE_LAST = 5'h0F;

    // Channel mode codes.
    localparam logic [3:0] CCPMC_M_OFF = 4'h0;
    localparam logic [3:0] CCPMC_M_TOGGLE = 4'h2;
    localparam logic [3:0] CCPMC_M_CAP_FALL = 4'h4;
    localparam logic [3:0] CCPMC_M_CAP_RISE = 4'h5;
    localparam logic [3:0] CCPMC_M_CAP_RISE16 = 4'h7;
    localparam logic [3:0] CCPMC_M_CMP_HIGH = 4'h8;
    localparam logic [3:0] CCPMC_M_CMP_LOW = 4'h9;
    localparam logic [3:0] CCPMC_M_SOFT = 4'hA;
    localparam logic [3:0] CCPMC_M_TRIGGER = 4'hB;
    localparam logic [3:0] CCPMC_M_PWM = 4'hC;

    // Control register contents.
    typedef struct packed {
        logic [1:0] duty_low_bits;
        logic [3:0] channel_mode_field;
    } ccpmc_control_t;

    // Interrupt status layout: bit 0 channel event.
    typedef struct packed {
        logic channel_irq_flag;
    } ccpmc_irq_t;

endpackage : ccpmc_pkg

// ---- ccpmc_edge.sv ----
// Edge detector for the channel input pin.
`timescale 1ns/1ps
module ccpmc_edge import ccpmc_pkg::*; (
    input wire logic clk,
    input wire logic srst,
    input wire logic pin_in,
    output logic rise,
    output logic fall
);
    logic prev;

    // Keep last pin level so edges last exactly one cycle.
    always_ff @(posedge clk) begin
        if (srst) begin
            prev <= 1'b0;
        end else begin
            prev <= pin_in;
        end
    end

    assign rise = pin_in & ~prev;
    assign fall = ~pin_in & prev;
endmodule : ccpmc_edge

// ---- ccpmc_pwm.sv ----
// Ten-bit PWM generator with a slave duty buffer.
`timescale 1ns/1ps
module ccpmc_pwm import ccpmc_pkg::*; (
    input wire logic clk,
    input wire logic srst,
    input wire logic run,
    input wire logic [9:0] duty,
    input wire logic [9:0] count,
    input wire logic period_start,
    output logic pwm_out,
    output logic [7:0] slave_high
);
    logic [9:0] slave_duty;

    // Duty is latched only at period start so a mid-period write cannot glitch.
    always_ff @(posedge clk) begin
        if (srst || !run) begin
            slave_duty <= 10'h000;
        end else if (period_start) begin
            slave_duty <= duty;
        end
    end

    // Output is high while the count is below the latched duty.
    always_ff @(posedge clk) begin
        if (srst || !run) begin
            pwm_out <= 1'b0;
        end else begin
            pwm_out <= (period_start ? duty : slave_duty) > count;
        end
    end

    assign slave_high = slave_duty[9:2];
endmodule : ccpmc_pwm

// ---- ccpmc_top.sv ----
// Capture/compare/PWM channel mode control with an Avalon-MM register slave.
//
// Summary of operation
// - Mode field in control bits 3-0 selects channel behaviour.
// - In PWM, control bits 5-4 are duty-cycle bits 1-0.
// - Duty bits 9-2 come from the data low byte.
// - Duty bits in control have no effect in capture or compare.
// - Mode 1001: pin high at setup, low plus flag on match.
// - Mode 1000: pin low at setup, high plus flag on match.
// - Mode 0010: toggle pin and set flag on every match.
// - Mode 0111: capture timer and flag every sixteenth rising edge.
// - Mode 0101: capture timer on every rising edge.
// - Mode 0100: capture timer on every falling edge.
// - Mode 1011: on match reset timer and set flag, no conversion start.
// - Capture and compare use both data bytes as one 16-bit value.
// - In PWM the high data byte is hidden; the slave duty buffer is held in the PWM core.
//
// The Avalon-MM interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module ccpmc_top import ccpmc_pkg::*; (
    input wire logic clk,
    input wire logic srst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [15:0] timer_value,
    input wire logic timer_period_start,
    output logic timer_reset,
    input wire logic channel_pin_in,
    output logic channel_pin_out,
    output logic channel_pin_oe,
    output logic irq
);
    // ************************************************************
    // Registers and internal state.
    // ************************************************************
    ccpmc_control_t control;
    logic [15:0] data;
    ccpmc_irq_t status;
    ccpmc_irq_t enable;
    logic [3:0] mode;
    logic [4:0] edge_count;
    logic [3:0] prev_mode;
    logic mode_changed;
    logic rise;
    logic fall;
    logic match;
    logic is_capture;
    logic is_compare;
    logic is_pwm;
    logic capture_event;
    logic compare_event;
    logic pwm_level;
    logic [7:0] slave_high;
    logic [9:0] pwm_duty;
    logic access_done;
    logic bus_wr;
    logic clear_hit;
    logic [31:0] next_readdata;

    // Mode decode; reserved codes fall into none of the groups below.
    assign mode = control.channel_mode_field;
    assign is_capture = (mode == CCPMC_M_CAP_FALL) || (mode == CCPMC_M_CAP_RISE)
        || (mode == CCPMC_M_CAP_RISE16);
    assign is_compare = (mode == CCPMC_M_TOGGLE) || (mode == CCPMC_M_CMP_HIGH)
        || (mode == CCPMC_M_CMP_LOW) || (mode == CCPMC_M_SOFT)
        || (mode == CCPMC_M_TRIGGER);
    assign is_pwm = (mode == CCPMC_M_PWM);
    assign mode_changed = (mode != prev_mode);
    assign match = is_compare && (timer_value == data);

    // ************************************************************
    // Avalon-MM slave: one wait cycle, then the answer.
    // ************************************************************
    assign bus_wr = avs_write && access_done;
    assign clear_hit = bus_wr && (avs_address == CCPMC_OFF_IRQ_CLEAR) && avs_byteenable[0];

    // Waitrequest idles high and drops for one cycle after each request is seen.
    // Registered so that it never loops combinationally back into the master.
    always_ff @(posedge clk) begin
        if (srst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
        end
    end

    assign access_done = !avs_waitrequest;

    // Control register write; bits 15-6 are not stored here, bit 8 goes to the interrupt enable.
    always_ff @(posedge clk) begin
        if (srst) begin
            control <= ccpmc_control_t'(CCPMC_CONTROL_RESET[5:0]);
        end else if (bus_wr && avs_address == CCPMC_OFF_CONTROL && avs_byteenable[0]) begin
            control <= ccpmc_control_t'(avs_writedata[5:0]);
        end
    end

    // Data register: software writes, capture overwrites, wins over software.
    // Cleared only on entry into off, so software may preload a compare value while off.
    always_ff @(posedge clk) begin
        if (srst || (mode == CCPMC_M_OFF && mode_changed)) begin
            data <= CCPMC_DATA_RESET;
        end else if (capture_event) begin
            data <= timer_value;
        end else if (bus_wr && avs_address == CCPMC_OFF_DATA) begin
            if (avs_byteenable[0]) begin
                data[7:0] <= avs_writedata[7:0];
            end
            if (avs_byteenable[1] && !is_pwm) begin
                data[15:8] <= avs_writedata[15:8];
            end
        end
    end

    // Read multiplexer; in PWM the high byte shows zero, it is not accessible.
    always_comb begin
        next_readdata = 32'h0000_0000;
        case (avs_address)
            CCPMC_OFF_CONTROL: next_readdata = {26'h000_0000, control};
            CCPMC_OFF_DATA: next_readdata = {16'h0000, is_pwm ? 8'h00 : data[15:8], data[7:0]};
            CCPMC_OFF_STATUS: next_readdata = {31'h0000_0000, status.channel_irq_flag};
            default: next_readdata = 32'h0000_0000;
        endcase
    end

    // Read data registered at the answering edge.
    always_ff @(posedge clk) begin
        if (srst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= next_readdata;
        end
    end

    // ************************************************************
    // Capture path.
    // ************************************************************
    // Edge pulses last one cycle; the detector idles low like the pin after reset.
    ccpmc_edge u_edge (
        .clk(clk),
        .srst(srst),
        .pin_in(channel_pin_in),
        .rise(rise),
        .fall(fall)
    );

    // Prescaler for the sixteen-edge mode restarts on any mode change.
    always_ff @(posedge clk) begin
        if (srst || mode_changed) begin
            edge_count <= 5'h00;
        end else if (mode == CCPMC_M_CAP_RISE16 && rise) begin
            edge_count <= (edge_count == CCPMC_PRESCALE_LAST) ? 5'h00 : edge_count + 5'h01;
        end
    end

    // Capture strobe for the three capture modes; reserved codes never capture.
    always_comb begin
        capture_event = 1'b0;
        case (mode)
            CCPMC_M_CAP_FALL: capture_event = fall;
            CCPMC_M_CAP_RISE: capture_event = rise;
            CCPMC_M_CAP_RISE16: capture_event = rise && (edge_count == CCPMC_PRESCALE_LAST);
            default: capture_event = 1'b0;
        endcase
    end

    // ************************************************************
    // Compare and PWM output path.
    // ************************************************************
    assign compare_event = match && !mode_changed;
    assign pwm_duty = {data[7:0], control.duty_low_bits};

    // The PWM core runs only in mode 1100; elsewhere it holds its buffer at zero.
    ccpmc_pwm u_pwm (
        .clk(clk),
        .srst(srst),
        .run(is_pwm),
        .duty(pwm_duty),
        .count(timer_value[9:0]),
        .period_start(timer_period_start),
        .pwm_out(pwm_level),
        .slave_high(slave_high)
    );

    // Remember the mode so entry into a compare mode sets the pin level.
    always_ff @(posedge clk) begin
        if (srst) begin
            prev_mode <= CCPMC_M_OFF;
        end else begin
            prev_mode <= mode;
        end
    end

    // Pin drive; duty bits are ignored outside PWM.
    always_ff @(posedge clk) begin
        if (srst) begin
            channel_pin_out <= 1'b0;
            channel_pin_oe <= 1'b0;
        end else begin
            channel_pin_oe <= is_compare || is_pwm;
            case (mode)
                CCPMC_M_CMP_LOW: channel_pin_out <= mode_changed ? 1'b1
                    : (compare_event ? 1'b0 : channel_pin_out);
                CCPMC_M_CMP_HIGH: channel_pin_out <= mode_changed ? 1'b0
                    : (compare_event ? 1'b1 : channel_pin_out);
                CCPMC_M_TOGGLE: channel_pin_out <= channel_pin_out ^ compare_event;
                CCPMC_M_PWM: channel_pin_out <= pwm_level;
                CCPMC_M_SOFT, CCPMC_M_TRIGGER: channel_pin_out <= channel_pin_out;
                default: channel_pin_out <= 1'b0;
            endcase
        end
    end

    // Timer reset pulse for the special event trigger mode.
    always_ff @(posedge clk) begin
        if (srst) begin
            timer_reset <= 1'b0;
        end else begin
            timer_reset <= compare_event && (mode == CCPMC_M_TRIGGER);
        end
    end

    // ************************************************************
    // Interrupt status, enable and clear; a new event beats a clear.
    // ************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            status <= '0;
        end else if (compare_event || capture_event) begin
            status.channel_irq_flag <= 1'b1;
        end else if (clear_hit && avs_writedata[0]) begin
            status.channel_irq_flag <= 1'b0;
        end
    end

    // Interrupt enable shares the control word, in its second byte.
    always_ff @(posedge clk) begin
        if (srst) begin
            enable <= '0;
        end else if (bus_wr && avs_address == CCPMC_OFF_IRQ_ENABLE && avs_byteenable[1]) begin
            enable.channel_irq_flag <= avs_writedata[8];
        end
    end

    // Level interrupt, registered so that the line never glitches.
    always_ff @(posedge clk) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= status.channel_irq_flag && enable.channel_irq_flag;
        end
    end

    // ************************************************************
    // Assertions.
    // ************************************************************
    sequence s_match_in_mode(logic [3:0] m);
        match && !mode_changed && mode == m;
    endsequence

    sequence s_bus_request;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence

    a_cmp_low_drive: assert property (@(posedge clk) disable iff (srst)
        s_match_in_mode(CCPMC_M_CMP_LOW) |=> !channel_pin_out && status.channel_irq_flag)
        else $error("pin not forced low on match");
    a_cmp_high_drive: assert property (@(posedge clk) disable iff (srst)
        s_match_in_mode(CCPMC_M_CMP_HIGH) |=> channel_pin_out && status.channel_irq_flag)
        else $error("pin not forced high on match");
    a_toggle_pin: assert property (@(posedge clk) disable iff (srst)
        s_match_in_mode(CCPMC_M_TOGGLE) |=> channel_pin_out != $past(channel_pin_out))
        else $error("pin did not toggle on match");
    a_cap_rise: assert property (@(posedge clk) disable iff (srst)
        (mode == CCPMC_M_CAP_RISE && rise) |=> data == $past(timer_value))
        else $error("rising capture missed");
    a_cap_fall: assert property (@(posedge clk) disable iff (srst)
        (mode == CCPMC_M_CAP_FALL && fall) |=> data == $past(timer_value))
        else $error("falling capture missed");
    a_cap_sixteen: assert property (@(posedge clk) disable iff (srst)
        mode == CCPMC_M_CAP_RISE16 && rise && edge_count == CCPMC_PRESCALE_LAST
        |=> data == $past(timer_value) && status.channel_irq_flag)
        else $error("sixteenth edge not captured");
    a_trig_reset: assert property (@(posedge clk) disable iff (srst)
        s_match_in_mode(CCPMC_M_TRIGGER) |=> timer_reset)
        else $error("timer not reset on trigger match");
    a_off_clears: assert property (@(posedge clk) disable iff (srst)
        mode == CCPMC_M_OFF && mode_changed |=> data == 16'h0000 && !channel_pin_oe)
        else $error("disabled channel kept state");
    a_off_pin: assert property (@(posedge clk) disable iff (srst)
        mode == CCPMC_M_OFF |=> !channel_pin_oe && !channel_pin_out)
        else $error("disabled channel drives pin");
    a_pwm_duty: assert property (@(posedge clk) disable iff (srst)
        is_pwm && $past(is_pwm) && $past(timer_period_start) |-> slave_high == $past(data[7:0]))
        else $error("slave duty buffer wrong");

    // Compare setup levels and the pin holding still between matches.
    a_cmp_init_low: assert property (@(posedge clk) disable iff (srst)
        mode_changed && mode == CCPMC_M_CMP_LOW |=> channel_pin_out && channel_pin_oe)
        else $error("pin not set high at setup");
    a_cmp_init_high: assert property (@(posedge clk) disable iff (srst)
        mode_changed && mode == CCPMC_M_CMP_HIGH |=> !channel_pin_out && channel_pin_oe)
        else $error("pin not set low at setup");
    a_duty_ignored: assert property (@(posedge clk) disable iff (srst)
        is_compare && !mode_changed && !match |=> $stable(channel_pin_out))
        else $error("compare pin moved without match");

    // Flag, clear and interrupt line.
    a_event_wins: assert property (@(posedge clk) disable iff (srst)
        compare_event || capture_event |=> status.channel_irq_flag)
        else $error("event did not set flag");
    a_flag_clear: assert property (@(posedge clk) disable iff (srst)
        clear_hit && avs_writedata[0] && !compare_event && !capture_event
        |=> !status.channel_irq_flag)
        else $error("flag not cleared");
    a_irq_level: assert property (@(posedge clk) disable iff (srst)
        status.channel_irq_flag && enable.channel_irq_flag |=> irq)
        else $error("enabled flag gave no interrupt");

    // Mode-specific outputs.
    a_trig_quiet: assert property (@(posedge clk) disable iff (srst)
        mode != CCPMC_M_TRIGGER |=> !timer_reset)
        else $error("timer reset outside trigger mode");
    a_hidden_high: assert property (@(posedge clk) disable iff (srst)
        is_pwm && bus_wr && avs_address == CCPMC_OFF_DATA |=> $stable(data[15:8]))
        else $error("hidden byte written in pwm");
    a_cap_input: assert property (@(posedge clk) disable iff (srst)
        is_capture |=> !channel_pin_oe)
        else $error("capture mode drives pin");
    a_pwm_follow: assert property (@(posedge clk) disable iff (srst)
        is_pwm |=> channel_pin_out == $past(pwm_level))
        else $error("pin does not follow pwm");

    // Bus handshake: one wait cycle, then back to the idle high level.
    a_wait_one: assert property (@(posedge clk) disable iff (srst)
        s_bus_request |=> !avs_waitrequest)
        else $error("waitrequest held too long");
    a_wait_idle: assert property (@(posedge clk) disable iff (srst)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for two cycles");
endmodule : ccpmc_top

// ---- ccpmc_far_model.sv ----
// Far-side model of the channel: a wrapping time base and the channel pin wire.
`timescale 1ns/1ps
module ccpmc_far_model import ccpmc_pkg::*; #(
    parameter int PERIOD = 256
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic timer_reset,
    input wire logic pin_out,
    input wire logic pin_oe,
    input wire logic pin_ext,
    output logic [15:0] timer_value,
    output logic timer_period_start,
    output logic pin_in
);
    // ************************************************************
    // Time base and pin
    // ************************************************************
    // The count wraps early so that matches recur every PERIOD cycles.
    always_ff @(posedge clk) begin
        if (srst || timer_reset || timer_value == 16'(PERIOD - 1)) begin
            timer_value <= 16'h0000;
        end else begin
            timer_value <= timer_value + 16'h0001;
        end
    end
    // A period starts at count zero; the channel wins the wire while it drives.
    assign timer_period_start = (timer_value == 16'h0000);
    assign pin_in = pin_oe ? pin_out : pin_ext;
endmodule : ccpmc_far_model

// ---- ccp_mode_control_test.sv ----
// Self-checking bench for the capture/compare/PWM mode control block.
`timescale 1ns/1ps
module ccp_mode_control_test import ccpmc_pkg::*;;
    // ************************************************************
    // Signals and instances
    // ************************************************************
    localparam int PERIOD = 256;
    logic clk = 1'h0;
    logic srst = 1'h1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, timer_reset, timer_period_start, irq;
    logic channel_pin_in, channel_pin_out, channel_pin_oe;
    logic pin_ext = 1'h0;
    logic [15:0] timer_value, t0;
    logic [31:0] rd;
    logic p;
    int n_fail = 0;
    int tests_run = 0;
    int k;

    ccpmc_top u_ccpmc_top (.clk(clk), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .timer_value(timer_value),
        .timer_period_start(timer_period_start), .timer_reset(timer_reset),
        .channel_pin_in(channel_pin_in), .channel_pin_out(channel_pin_out),
        .channel_pin_oe(channel_pin_oe), .irq(irq));
    ccpmc_far_model #(.PERIOD(PERIOD)) u_ccpmc_far_model (.clk(clk), .srst(srst),
        .timer_reset(timer_reset), .pin_out(channel_pin_out), .pin_oe(channel_pin_oe),
        .pin_ext(pin_ext), .timer_value(timer_value), .timer_period_start(timer_period_start),
        .pin_in(channel_pin_in));

    // Free-running 250 MHz clock.
    initial begin
        forever #2 clk = ~clk;
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic end_of_test;
        if (n_fail == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string s);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t %s got %h exp %h", $time, s, got, exp);
        end
    endtask : check

    // One bus cycle, held until waitrequest is sampled low; read data taken at that edge.
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !w;
        avs_write <= w;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (n > 50) begin
                n_fail++;
                $display("ERROR %0t bus timeout", $time);
                end_of_test();
            end
        end while (avs_waitrequest !== 1'h0);
        rd = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
    endtask : bus

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
        input string s);
        bus(1'h0, a, 32'h0000_0000);
        check(rd & m, e, s);
    endtask : rd_chk

    // Waits for the pin (sel 0) or the timer reset (sel 1) to reach v; n counts edges.
    task automatic wait_sig(input logic sel, input logic v, output int n);
        n = 0;
        while ((sel ? timer_reset : channel_pin_out) !== v) begin
            @(posedge clk);
            n++;
            if (n > 700) begin
                n_fail++;
                $display("ERROR %0t wait timeout", $time);
                end_of_test();
            end
        end
    endtask : wait_sig

    // True when b trails a by no more than lim counts of the wrapping time base.
    function automatic logic [31:0] near(input logic [15:0] a, input logic [15:0] b, int lim);
        return 32'(((b - a) & 16'h00FF) <= 16'(lim));
    endfunction : near

    // Compare setup with duty bits set, which must not matter outside PWM.
    task automatic cmp_setup(input logic [3:0] m, input logic en);
        t0 = (timer_value + 16'h0040) & 16'h00FF;
        bus(1'h1, CCPMC_OFF_DATA, {16'h0000, t0});
        bus(1'h1, CCPMC_OFF_CONTROL, {23'h00_0000, en, 2'h0, 2'h3, m});
        repeat (2) @(posedge clk);
    endtask : cmp_setup

    task automatic flag_clear(input logic e);
        rd_chk(CCPMC_OFF_STATUS, 32'h0000_0001, 32'h0000_0001, "flag set");
        check(irq, e, "irq level");
        bus(1'h1, CCPMC_OFF_IRQ_CLEAR, 32'h0000_0001);
        rd_chk(CCPMC_OFF_STATUS, 32'h0000_0001, 32'h0000_0000, "flag clear");
    endtask : flag_clear

    // One input pulse; t0 holds the time base at its rising edge.
    task automatic pulse;
        @(posedge clk);
        pin_ext <= 1'h1;
        t0 = timer_value;
        repeat (4) @(posedge clk);
        pin_ext <= 1'h0;
        repeat (4) @(posedge clk);
    endtask : pulse

    task automatic cap_mode(input logic [3:0] m);
        bus(1'h1, CCPMC_OFF_CONTROL, 32'h0000_0100);
        bus(1'h1, CCPMC_OFF_CONTROL, {24'h00_0001, 4'h0, m});
    endtask : cap_mode

    // ************************************************************
    // Sequence
    // ************************************************************
    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        $display("ERROR %0t run timeout", $time);
        end_of_test();
    end

    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'h0;
        rd_chk(CCPMC_OFF_CONTROL, 32'h0000_00FF, 32'h0000_0000, "control reset");
        rd_chk(CCPMC_OFF_DATA, 32'h0000_FFFF, 32'h0000_0000, "data reset");
        rd_chk(4'h6, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
        bus(1'h1, CCPMC_OFF_CONTROL, 32'h0000_00FC);
        rd_chk(CCPMC_OFF_CONTROL, 32'h0000_00FF, 32'h0000_003C, "fields");
        // Match never reached here, so the toggle mode must stay quiet.
        bus(1'h1, CCPMC_OFF_CONTROL, 32'h0000_0132);
        bus(1'h1, CCPMC_OFF_DATA, 32'h0000_A5C3);
        avs_byteenable <= 4'h1;
        bus(1'h1, CCPMC_OFF_DATA, 32'h0000_FF11);
        avs_byteenable <= 4'hF;
        rd_chk(CCPMC_OFF_DATA, 32'h0000_FFFF, 32'h0000_A511, "16-bit data");
        rd_chk(CCPMC_OFF_STATUS, 32'h0000_0001, 32'h0000_0000, "no match");
        // Toggle period equals the time base period.
        cmp_setup(CCPMC_M_TOGGLE, 1'h1);
        p = channel_pin_out;
        wait_sig(1'h0, !p, k);
        wait_sig(1'h0, p, k);
        check(32'(k), 32'(PERIOD), "toggle period");
        flag_clear(1'h1);
        bus(1'h1, CCPMC_OFF_CONTROL, 32'h0000_0100);
        repeat (2) @(posedge clk);
        check({channel_pin_oe, channel_pin_out}, 2'h0, "off pin");
        repeat (300) @(posedge clk);
        rd_chk(CCPMC_OFF_STATUS, 32'h0000_0001, 32'h0000_0000, "off quiet");
        cmp_setup(CCPMC_M_CMP_HIGH, 1'h1);
        check({channel_pin_oe, channel_pin_out}, 2'h2, "init low");
        wait_sig(1'h0, 1'h1, k);
        check(near(t0, timer_value, 3), 1, "rise at match");
        flag_clear(1'h1);
        cmp_setup(CCPMC_M_CMP_LOW, 1'h0);
        check({channel_pin_oe, channel_pin_out}, 2'h3, "init high");
        wait_sig(1'h0, 1'h0, k);
        check(near(t0, timer_value, 3), 1, "fall at match");
        flag_clear(1'h0);
        cmp_setup(CCPMC_M_TRIGGER, 1'h1);
        wait_sig(1'h1, 1'h1, k);
        check(near(t0, timer_value, 3), 1, "trigger at match");
        repeat (2) @(posedge clk);
        check(32'(timer_value <= 16'h0002), 1, "timer restarted");
        flag_clear(1'h1);
        cmp_setup(CCPMC_M_SOFT, 1'h1);
        repeat (300) @(posedge clk);
        check(channel_pin_oe, 1'h1, "soft drives");
        flag_clear(1'h1);
        cap_mode(CCPMC_M_CAP_RISE);
        check(channel_pin_oe, 1'h0, "capture input");
        pulse();
        rd_chk(CCPMC_OFF_DATA, 32'h0000_0000, 32'h0000_0000, "read");
        check(near(t0, rd[15:0], 8), 1, "rise capture");
        flag_clear(1'h1);
        cap_mode(CCPMC_M_CAP_FALL);
        @(posedge clk);
        pin_ext <= 1'h1;
        repeat (8) @(posedge clk);
        rd_chk(CCPMC_OFF_STATUS, 32'h0000_0001, 32'h0000_0000, "rise ignored");
        @(posedge clk);
        pin_ext <= 1'h0;
        t0 = timer_value;
        repeat (8) @(posedge clk);
        rd_chk(CCPMC_OFF_DATA, 32'h0000_0000, 32'h0000_0000, "read");
        check(near(t0, rd[15:0], 8), 1, "fall capture");
        flag_clear(1'h1);
        cap_mode(CCPMC_M_CAP_RISE16);
        repeat (15) pulse();
        rd_chk(CCPMC_OFF_STATUS, 32'h0000_0001, 32'h0000_0000, "15 edges");
        pulse();
        rd_chk(CCPMC_OFF_DATA, 32'h0000_0000, 32'h0000_0000, "read");
        check(near(t0, rd[15:0], 8), 1, "16th capture");
        flag_clear(1'h1);
        // Duty of 129: high byte 0x20 from data, low bits 01 from control.
        bus(1'h1, CCPMC_OFF_CONTROL, 32'h0000_0100);
        bus(1'h1, CCPMC_OFF_DATA, 32'h0000_0020);
        bus(1'h1, CCPMC_OFF_CONTROL, 32'h0000_011C);
        bus(1'h1, CCPMC_OFF_DATA, 32'h0000_7720);
        rd_chk(CCPMC_OFF_DATA, 32'h0000_FFFF, 32'h0000_0020, "slave hidden");
        repeat (600) @(posedge clk);
        k = 0;
        repeat (PERIOD) begin
            @(posedge clk);
            if (channel_pin_out === 1'h1) k++;
        end
        check(32'(k >= 128 && k <= 130), 1, "duty high time");
        check(channel_pin_oe, 1'h1, "pwm drives");
        end_of_test();
    end
endmodule : ccp_mode_control_test
